// >>> verilog/led_and_phy_control_regs.sv
// indicator and phy control register bank behind the management port
// assumes the serial frame engine gives one-cycle read/write strobes on clk
// What this block does
// - two-bit rate code blinks indicator at 50, 100, 200 or 500 ms phases
// - indicator polarity comes from reset strap, writable bit overrides it
// - manual select puts forced level on first indicator pin
// - forced level bit sits at position 1 and resets to zero
// - auto crossover enable bit resets to one, strap may override
// - forced crossover swaps receive and transmit pairs
// - pause receive status bit derived from both pause ability pairs
// - pause transmit status bit derived from both pause ability pairs
// - pause bits set only for full duplex, standard resolution table
// - link status bit high only for negotiated 100 full-duplex link
// - stretch skip bit drives indicator straight from the event
// - indicator register at offset 0x18, reset value 0x400
`timescale 1ns/1ps
module led_and_phy_control_regs
#(
	parameter int MS_CYCLES_P = led_phy_pkg::MS_CYCLES
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// management register port
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic [15:0] mgmt_wdata,
	input  wire logic        mgmt_wr,
	input  wire logic        mgmt_rd,
	output logic [15:0]      mgmt_rdata,
	output logic             mgmt_rvalid,
	// strap pins
	input  wire logic        strap_active_level,
	input  wire logic        strap_auto_crossover,
	// negotiation results
	input  wire logic        an_complete,
	input  wire logic        an_full_duplex,
	input  wire logic        an_speed_100,
	input  wire logic        link_up,
	input  wire logic [1:0]  local_ability_advert,
	input  wire logic [1:0]  partner_ability,
	input  wire logic        link_event,
	// indicator and pair controls
	output logic             first_indicator_pin,
	output logic             auto_crossover_en,
	output logic             forced_crossover,
	output logic             pause_rx_en,
	output logic             pause_tx_en,
	output logic             mii_link_up
);
	import led_phy_pkg::*;

	typedef struct packed {
		logic [2:0]  sync_level;
		logic [2:0]  sync_xover;
		logic [2:0]  sync_fill;
		logic        strap_done;
		logic [1:0]  blink_rate;
		logic        active_level;
		logic        manual_select;
		logic        forced_level;
		logic        auto_xover;
		logic        forced_xover;
		logic        stretch_skip;
		logic        led_config;
		logic        pause_rx;
		logic        pause_tx;
		logic        mii_link;
		logic        pin;
		logic [15:0] rdata;
		logic        rvalid;
	} ctrl_state_t;

	ctrl_state_t state_reg;
	ctrl_state_t state_next;
	logic        blink_active;
	logic        blink_phase;
	logic        hcd_full;
	logic        led_on;
	logic [15:0] led_word;
	logic [15:0] phy_word;
	logic        wr_led;
	logic        wr_phy;

	// blink timer, started by link events
	indicator_blinker
	#(
		.MS_CYCLES_P (MS_CYCLES_P)
	)
	u_blinker
	(
		.clk    (clk),
		.rst    (rst),
		.rate   (state_reg.blink_rate),
		.start  (link_event),
		.active (blink_active),
		.phase  (blink_phase)
	);

	// decode; tenbase register is owned elsewhere and reads zero here
	assign wr_led   = mgmt_wr && (mgmt_addr == LED_CONTROL_ADDR);
	assign wr_phy   = mgmt_wr && (mgmt_addr == PHY_CONTROL_ADDR);
	assign hcd_full = an_complete && an_full_duplex;

	// read words; reserved bits and unlisted fields read zero
	always_comb
	begin
		led_word = 16'h0;
		led_word[LED_RATE_HI:LED_RATE_LO] = state_reg.blink_rate;
		led_word[LED_ACTIVE_LEVEL]        = state_reg.active_level;
		led_word[LED_MANUAL_SELECT]       = state_reg.manual_select;
		led_word[LED_FORCED_LEVEL]        = state_reg.forced_level;
		phy_word = 16'h0;
		phy_word[PHY_AUTO_XOVER]          = state_reg.auto_xover;
		phy_word[PHY_FORCED_XOVER]        = state_reg.forced_xover;
		phy_word[PHY_PAUSE_RX]            = state_reg.pause_rx;
		phy_word[PHY_PAUSE_TX]            = state_reg.pause_tx;
		phy_word[PHY_MII_LINK]            = state_reg.mii_link;
		phy_word[PHY_STRETCH_SKIP]        = state_reg.stretch_skip;
		phy_word[PHY_LED_CONFIG]          = state_reg.led_config;
	end

	// indicator drive; stretching keeps short events visible
	always_comb
	begin
		if (state_reg.stretch_skip)
			led_on = link_up && !link_event;
		else
			led_on = link_up && !(blink_active && !blink_phase);
	end

	// next state
	always_comb
	begin
		state_next = state_reg;
		// straps pass three flops; caught once the last two agree
		// the fill marker keeps reset zeros in the stages from agreeing early
		state_next.sync_level = {state_reg.sync_level[1:0],
			strap_active_level};
		state_next.sync_xover = {state_reg.sync_xover[1:0],
			strap_auto_crossover};
		state_next.sync_fill  = {state_reg.sync_fill[1:0], 1'b1};
		if (!state_reg.strap_done && state_reg.sync_fill[2] &&
			(state_reg.sync_level[1] == state_reg.sync_level[2]) &&
			(state_reg.sync_xover[1] == state_reg.sync_xover[2]))
		begin
			state_next.strap_done   = 1'b1;
			state_next.active_level = state_reg.sync_level[2];
			state_next.auto_xover   = state_reg.sync_xover[2];
		end
		// a write in the same cycle beats the strap capture
		if (wr_led)
		begin
			state_next.blink_rate    =
				mgmt_wdata[LED_RATE_HI:LED_RATE_LO];
			state_next.active_level  = mgmt_wdata[LED_ACTIVE_LEVEL];
			state_next.manual_select = mgmt_wdata[LED_MANUAL_SELECT];
			state_next.forced_level  = mgmt_wdata[LED_FORCED_LEVEL];
		end
		if (wr_phy)
		begin
			state_next.auto_xover   = mgmt_wdata[PHY_AUTO_XOVER];
			state_next.forced_xover = mgmt_wdata[PHY_FORCED_XOVER];
			state_next.stretch_skip = mgmt_wdata[PHY_STRETCH_SKIP];
			state_next.led_config   = mgmt_wdata[PHY_LED_CONFIG];
		end
		// pause resolution, gated by full-duplex common denominator
		state_next.pause_rx = hcd_full && (
			(local_ability_advert[ABIL_PAUSE] &&
			 partner_ability[ABIL_PAUSE]) ||
			(local_ability_advert[ABIL_PAUSE] &&
			 local_ability_advert[ABIL_ASYM] &&
			 !partner_ability[ABIL_PAUSE] &&
			 partner_ability[ABIL_ASYM]));
		state_next.pause_tx = hcd_full && (
			(local_ability_advert[ABIL_PAUSE] &&
			 partner_ability[ABIL_PAUSE]) ||
			(!local_ability_advert[ABIL_PAUSE] &&
			 local_ability_advert[ABIL_ASYM] &&
			 partner_ability[ABIL_PAUSE] &&
			 partner_ability[ABIL_ASYM]));
		state_next.mii_link = hcd_full && an_speed_100 && link_up;
		// manual drive bypasses polarity: the forced level is the pin
		if (state_reg.manual_select)
			state_next.pin = state_reg.forced_level;
		else
			state_next.pin = state_reg.active_level ? led_on : !led_on;
		// read answer one cycle after the strobe
		state_next.rvalid = mgmt_rd;
		if (mgmt_rd && mgmt_addr == LED_CONTROL_ADDR)
			state_next.rdata = led_word;
		else if (mgmt_rd && mgmt_addr == PHY_CONTROL_ADDR)
			state_next.rdata = phy_word;
		else if (mgmt_rd)
			state_next.rdata = 16'h0;
	end

	// state register; reset values follow the documented words
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg            <= '0;
			state_reg.blink_rate <= LED_RESET[LED_RATE_HI:LED_RATE_LO];
			state_reg.auto_xover <= PHY_RESET[PHY_AUTO_XOVER];
			state_reg.pin        <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	assign first_indicator_pin = state_reg.pin;
	assign auto_crossover_en   = state_reg.auto_xover;
	assign forced_crossover    = state_reg.forced_xover;
	assign pause_rx_en         = state_reg.pause_rx;
	assign pause_tx_en         = state_reg.pause_tx;
	assign mii_link_up         = state_reg.mii_link;
	assign mgmt_rdata          = state_reg.rdata;
	assign mgmt_rvalid         = state_reg.rvalid;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	rate_write_a: assert property (wr_led |=>
		state_reg.blink_rate == $past(mgmt_wdata[LED_RATE_HI:LED_RATE_LO]))
		else $error("blink rate not taken from write");
	polarity_a: assert property (!state_reg.manual_select && !link_up
		|=> first_indicator_pin == !$past(state_reg.active_level))
		else $error("idle indicator level wrong for polarity");
	manual_drive_a: assert property (state_reg.manual_select
		|=> first_indicator_pin == $past(state_reg.forced_level))
		else $error("manual drive not on pin");
	forced_level_a: assert property (wr_led ##1 !mgmt_wr ##1
		(mgmt_rd && mgmt_addr == LED_CONTROL_ADDR && !mgmt_wr) |=>
		mgmt_rdata[LED_FORCED_LEVEL] ==
		$past(mgmt_wdata[LED_FORCED_LEVEL], 3))
		else $error("forced level not read back");
	auto_xover_a: assert property (wr_phy |=>
		auto_crossover_en == $past(mgmt_wdata[PHY_AUTO_XOVER]))
		else $error("auto crossover not taken");
	forced_xover_a: assert property (wr_phy |=>
		forced_crossover == $past(mgmt_wdata[PHY_FORCED_XOVER]))
		else $error("forced crossover not taken");
	pause_sym_a: assert property (hcd_full && local_ability_advert[0]
		&& partner_ability[0] |=> pause_rx_en && pause_tx_en)
		else $error("symmetric pause not resolved");
	pause_asym_a: assert property (hcd_full &&
		local_ability_advert == 2'h2 && partner_ability == 2'h3
		|=> pause_tx_en && !pause_rx_en)
		else $error("asymmetric transmit pause not resolved");
	pause_gate_a: assert property (!an_full_duplex
		|=> !pause_rx_en && !pause_tx_en)
		else $error("pause set without full duplex");
	mii_link_a: assert property (mii_link_up |->
		$past(an_complete && an_full_duplex && an_speed_100 && link_up))
		else $error("link status without negotiated 100 full duplex");
	stretch_skip_a: assert property (state_reg.stretch_skip &&
		!state_reg.manual_select && link_up && link_event
		|=> first_indicator_pin == !$past(state_reg.active_level))
		else $error("bypass did not follow the event");
	reserved_zero_a: assert property (mgmt_rd &&
		mgmt_addr == LED_CONTROL_ADDR |=> mgmt_rvalid &&
		mgmt_rdata[15:11] == 5'h0 && mgmt_rdata[8] == 1'b0)
		else $error("reserved bits not zero");

	// strap capture, read map, status and idle indicator checks
	phy_reserved_a: assert property (mgmt_rd &&
		mgmt_addr == PHY_CONTROL_ADDR |=> mgmt_rvalid &&
		mgmt_rdata[10:8] == 3'h0 && mgmt_rdata[6] == 1'b0 &&
		mgmt_rdata[4:0] == 5'h00)
		else $error("phy reserved bits not zero");
	unmapped_zero_a: assert property (mgmt_rd &&
		mgmt_addr != LED_CONTROL_ADDR && mgmt_addr != PHY_CONTROL_ADDR
		|=> mgmt_rdata == 16'h0000)
		else $error("unmapped register not zero");
	strap_level_a: assert property ($rose(state_reg.strap_done) &&
		!$past(wr_led) |-> state_reg.active_level ==
		$past(strap_active_level, 4))
		else $error("polarity strap not captured");
	strap_xover_a: assert property ($rose(state_reg.strap_done) &&
		!$past(wr_phy) |-> auto_crossover_en ==
		$past(strap_auto_crossover, 4))
		else $error("crossover strap not captured");
	mii_down_a: assert property (!link_up |=> !mii_link_up)
		else $error("link status set while link down");
	status_ro_a: assert property (wr_phy && !hcd_full
		|=> !pause_rx_en && !pause_tx_en && !mii_link_up)
		else $error("status bits taken from a write");
	normal_pin_a: assert property (!state_reg.stretch_skip &&
		!state_reg.manual_select && link_up && !blink_active
		|=> first_indicator_pin == $past(state_reg.active_level))
		else $error("idle indicator not lit");

	manual_cov: cover property (wr_led && mgmt_wdata[LED_MANUAL_SELECT]
		##1 state_reg.manual_select);
	blink_cov: cover property (blink_active && blink_phase);
	pause_cov: cover property (pause_rx_en && pause_tx_en && mii_link_up);
	strap_cov: cover property ($rose(state_reg.strap_done));
	skip_cov: cover property (state_reg.stretch_skip && link_event &&
		link_up);

endmodule // led_and_phy_control_regs

// >>> include/led_phy_pkg.sv
// offsets, field positions, reset values and timing counts shared by the
// indicator and phy control register bank and its blink timer
package led_phy_pkg;

	// management register offsets (5-bit register address)
	localparam logic [4:0]  LED_CONTROL_ADDR  = 5'h18;
	localparam logic [4:0]  PHY_CONTROL_ADDR  = 5'h19;
	localparam logic [4:0]  TENBASE_ADDR      = 5'h1a;

	// led_control field positions
	localparam int          LED_RATE_LO       = 9;
	localparam int          LED_RATE_HI       = 10;
	localparam int          LED_ACTIVE_LEVEL  = 7;
	localparam int          LED_MANUAL_SELECT = 4;
	localparam int          LED_FORCED_LEVEL  = 1;
	localparam logic [15:0] LED_RESET         = 16'h0400;
	localparam logic [1:0]  LED_RATE_RESET    = 2'h2;

	// phy_control field positions
	localparam int          PHY_AUTO_XOVER    = 15;
	localparam int          PHY_FORCED_XOVER  = 14;
	localparam int          PHY_PAUSE_RX      = 13;
	localparam int          PHY_PAUSE_TX      = 12;
	localparam int          PHY_MII_LINK      = 11;
	localparam int          PHY_STRETCH_SKIP  = 7;
	localparam int          PHY_LED_CONFIG    = 5;
	localparam logic [15:0] PHY_RESET         = 16'h8000;

	// pause bits inside the ability words [11:10]
	localparam int          ABIL_PAUSE        = 0;
	localparam int          ABIL_ASYM         = 1;

	// blink phase lengths in milliseconds, one per rate code
	localparam logic [8:0]  PHASE_MS_0        = 9'd50;
	localparam logic [8:0]  PHASE_MS_1        = 9'd100;
	localparam logic [8:0]  PHASE_MS_2        = 9'd200;
	localparam logic [8:0]  PHASE_MS_3        = 9'd500;

	// clock rate and the cycles in one millisecond
	localparam int          CLK_HZ            = 10_000_000;
	localparam int          MS_PER_S          = 1000;
	localparam int          MS_CYCLES         = CLK_HZ / MS_PER_S;
	localparam logic [1:0]  STRETCH_PHASES    = 2'h2;

endpackage

// >>> verilog/indicator_blinker.sv
// blink timer: millisecond divider plus phase counter for the indicator
// assumes one clock, async active-high reset, start from the same clock
`timescale 1ns/1ps
module indicator_blinker
#(
	parameter int MS_CYCLES_P = led_phy_pkg::MS_CYCLES
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic [1:0] rate,
	input  wire logic       start,
	// status
	output logic            active,
	output logic            phase
);
	import led_phy_pkg::*;

	typedef struct packed {
		logic [13:0] ms_cnt;
		logic [8:0]  phase_ms;
		logic        phase;
		logic [1:0]  left;
	} blink_state_t;

	blink_state_t state_reg;
	blink_state_t state_next;
	logic [8:0]   phase_len;
	logic         ms_tick;

	// phase length per rate code
	always_comb
	begin
		case (rate)
			2'h0:    phase_len = PHASE_MS_0;
			2'h1:    phase_len = PHASE_MS_1;
			2'h2:    phase_len = PHASE_MS_2;
			2'h3:    phase_len = PHASE_MS_3;
			default: phase_len = PHASE_MS_2;
		endcase
	end

	assign ms_tick = (state_reg.ms_cnt == 14'(MS_CYCLES_P - 1));

	// a new event restarts only when idle, so bursts do not freeze the led
	always_comb
	begin
		state_next = state_reg;
		state_next.ms_cnt = ms_tick ? 14'h0 : state_reg.ms_cnt + 14'h1;
		if (state_reg.left == 2'h0)
		begin
			state_next.phase_ms = 9'h0;
			state_next.phase    = 1'b0;
			if (start)
			begin
				state_next.left   = STRETCH_PHASES;
				state_next.ms_cnt = 14'h0;
			end
		end
		else if (ms_tick)
		begin
			if (state_reg.phase_ms == phase_len - 9'h1)
			begin
				state_next.phase_ms = 9'h0;
				state_next.phase    = ~state_reg.phase;
				state_next.left     = state_reg.left - 2'h1;
			end
			else
				state_next.phase_ms = state_reg.phase_ms + 9'h1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign active = (state_reg.left != 2'h0);
	assign phase  = state_reg.phase;

endmodule // indicator_blinker

// >>> sim/tb_top.sv
// self-checking bench for the indicator and phy control register bank
// assumes led_phy_pkg is compiled first; bench drives all ports itself
`timescale 1ns/1ps
module tb_top;
	import led_phy_pkg::*;
	localparam int MS = 4; // short millisecond keeps blink phases brief
	logic        clk, rst, mgmt_wr, mgmt_rd, mgmt_rvalid;
	logic [4:0]  mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, phy_w, rnd;
	logic        strap_active_level, strap_auto_crossover;
	logic        an_complete, an_full_duplex, an_speed_100, link_up;
	logic [1:0]  local_ability_advert, partner_ability, pe;
	logic        link_event, first_indicator_pin;
	logic        auto_crossover_en, forced_crossover;
	logic        pause_rx_en, pause_tx_en, mii_link_up;
	logic [15:0] exp_q [$];
	int          mismatches, n_compared, ph;

	led_and_phy_control_regs #(.MS_CYCLES_P(MS)) i_dut (.clk(clk), .rst(rst),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr),
		.mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid), .strap_active_level(strap_active_level),
		.strap_auto_crossover(strap_auto_crossover),
		.an_complete(an_complete), .an_full_duplex(an_full_duplex),
		.an_speed_100(an_speed_100), .link_up(link_up),
		.local_ability_advert(local_ability_advert),
		.partner_ability(partner_ability), .link_event(link_event),
		.first_indicator_pin(first_indicator_pin),
		.auto_crossover_en(auto_crossover_en),
		.forced_crossover(forced_crossover), .pause_rx_en(pause_rx_en),
		.pause_tx_en(pause_tx_en), .mii_link_up(mii_link_up));

	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// read answers are matched against the oldest queued note
	always @(negedge clk)
		if (mgmt_rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(mgmt_rdata, 16'hxxxx);
			else
				chk(mgmt_rdata, exp_q.pop_front());
		end

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(negedge clk);
		mgmt_wr = 1'b0;
		mgmt_wdata = ~d; // stale data must not leak into the register
	endtask

	task automatic reg_rd(input logic [4:0] a, input logic [15:0] e);
		@(negedge clk);
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk);
		mgmt_rd = 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic do_reset(input logic lvl, input logic xo);
		strap_active_level = lvl;
		strap_auto_crossover = xo;
		rst = 1'b1;
		settle(5);
		rst = 1'b0;
		settle(6); // straps land before the first write
	endtask

	function automatic logic [15:0] xs(input logic [15:0] s);
		s ^= s << 7;
		s ^= s >> 9;
		s ^= s << 8;
		return s;
	endfunction

	// standard pause resolution, {rx, tx}
	function automatic logic [1:0] pz(input logic [1:0] l, input logic [1:0] p,
		input logic fd);
		if (!fd)
			return 2'h0;
		if (l[ABIL_PAUSE] && p[ABIL_PAUSE])
			return 2'h3;
		if (l == 2'h2 && p == 2'h3)
			return 2'h1;
		if (l == 2'h3 && p == 2'h2)
			return 2'h2;
		return 2'h0;
	endfunction

	task automatic results;
		if (exp_q.size() != 0)
			mismatches++;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watchdog sized well above the expected run of about 9400 cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		mismatches++;
		results();
	end

	initial
	begin
		{mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = '0;
		{an_complete, an_full_duplex, an_speed_100, link_up} = 4'h0;
		{local_ability_advert, partner_ability, link_event} = 5'h00;
		mismatches = 0;
		n_compared = 0;
		rnd = 16'h0056;
		do_reset(1'b0, 1'b1);
		reg_rd(LED_CONTROL_ADDR, 16'h0400);
		reg_rd(PHY_CONTROL_ADDR, 16'h8000);
		reg_rd(TENBASE_ADDR, 16'h0000);
		// random writes, reserved and status bits must not stick
		repeat (8)
		begin
			rnd = xs(rnd);
			reg_wr(LED_CONTROL_ADDR, rnd);
			reg_rd(LED_CONTROL_ADDR, rnd & 16'h0692);
			reg_wr(PHY_CONTROL_ADDR, ~rnd);
			reg_rd(PHY_CONTROL_ADDR, ~rnd & 16'hc0a0);
			reg_wr(TENBASE_ADDR, rnd);
			reg_rd(TENBASE_ADDR, 16'h0000);
		end
		// crossover controls at the pins
		for (int i = 0; i < 4; i++)
		begin
			reg_wr(PHY_CONTROL_ADDR, {i[1:0], 14'h0000});
			settle(2);
			chk({14'h0000, auto_crossover_en, forced_crossover}, i[15:0]);
		end
		// pause resolution over every ability pair, duplex on and off
		phy_w = 16'h0000;
		reg_wr(PHY_CONTROL_ADDR, phy_w); // crossover bits back to zero
		an_complete = 1'b1;
		for (int i = 0; i < 32; i++)
		begin
			{an_full_duplex, local_ability_advert, partner_ability} = i[4:0];
			pe = pz(local_ability_advert, partner_ability, an_full_duplex);
			settle(2);
			chk({14'h0000, pause_rx_en, pause_tx_en}, {14'h0000, pe});
			reg_rd(PHY_CONTROL_ADDR, {2'h0, pe, 12'h000});
		end
		{local_ability_advert, partner_ability} = 4'h0;
		// negotiated 100 full-duplex link status
		for (int i = 0; i < 16; i++)
		begin
			{an_complete, an_full_duplex, an_speed_100, link_up} = i[3:0];
			settle(2);
			chk({15'h0000, mii_link_up}, {15'h0000, &i[3:0]});
			reg_rd(PHY_CONTROL_ADDR, {4'h0, &i[3:0], 11'h000});
		end
		// manual drive ignores polarity and link state
		for (int i = 0; i < 8; i++)
		begin
			link_up = i[2];
			reg_wr(LED_CONTROL_ADDR, {8'h00, i[1], 2'h0, 1'b1, 2'h0, i[0], 1'h0});
			settle(2);
			chk({15'h0000, first_indicator_pin}, {15'h0000, i[0]});
		end
		// stretch skipped: pin follows event directly, both polarities
		reg_wr(PHY_CONTROL_ADDR, 16'h0080);
		for (int i = 0; i < 8; i++)
		begin
			{link_up, link_event} = i[1:0];
			reg_wr(LED_CONTROL_ADDR, {8'h00, i[2], 7'h00});
			settle(2);
			chk({15'h0000, first_indicator_pin},
				{15'h0000, i[2] ~^ (i[1] & !i[0])});
		end
		// stretched blink at every rate code, a second event is ignored
		link_event = 1'b0;
		settle(2 * MS * PHASE_MS_0); // blink started above must run out
		link_up = 1'b1;
		reg_wr(PHY_CONTROL_ADDR, 16'h0000);
		for (int r = 0; r < 4; r++)
		begin
			ph = MS * ((r == 0) ? PHASE_MS_0 : (r == 1) ? PHASE_MS_1 :
				(r == 2) ? PHASE_MS_2 : PHASE_MS_3);
			reg_wr(LED_CONTROL_ADDR, {5'h00, r[1:0], 9'h080});
			reg_rd(LED_CONTROL_ADDR, {5'h00, r[1:0], 9'h080});
			settle(4);
			chk({15'h0000, first_indicator_pin}, 16'h0001);
			link_event = 1'b1;
			settle(1);
			link_event = 1'b0;
			settle(ph / 2);
			chk({15'h0000, first_indicator_pin}, 16'h0000);
			link_event = 1'b1;
			settle(ph / 4);
			link_event = 1'b0;
			settle(ph * 3 / 4);
			chk({15'h0000, first_indicator_pin}, 16'h0001);
			settle(ph);
		end
		// second reset with opposite straps, then override polarity
		do_reset(1'b1, 1'b0);
		reg_rd(LED_CONTROL_ADDR, 16'h0480);
		reg_rd(PHY_CONTROL_ADDR, 16'h0800);
		reg_wr(LED_CONTROL_ADDR, 16'h0400);
		reg_rd(LED_CONTROL_ADDR, 16'h0400);
		settle(4);
		results();
	end
endmodule // tb_top
